// ---- bench/dwss_core_bench.sv ----
`timescale 1ns/100ps
module dwss_core_bench
  import dwss_pkg::*;
;
  logic              clk = 0, reset_n = 0, data_write_sat_enable = 0;
  logic              store_valid, store_clamped, shift_done;
  logic [ACC_W-1:0]  accumulator_a, accumulator_b, shift_acc_result, a_in = 0, b_in = 0;
  logic [ACC_W-1:0]  pa = 0, pb = 0, op, m_acc = 0;
  logic [WORD_W-1:0] x_bus = 0, store_data, shift_word_result, m_wd = 0;
  logic [16:0]       es;
  dwss_store_req_t   store_req = '0;
  dwss_shift_req_t   shift_req = '0;
  int                n_fail = 0, n_checks = 0, n, s;
  // core clock, 10 ns
  always #5 clk = ~clk;
  dwss_partner dwss_partner_inst (.*);
  dwss_core dwss_core_inst (.*);
  // one compare against the model
  task chk(input logic [ACC_W-1:0] seen, input logic [ACC_W-1:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task tally_and_finish;
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : tally_and_finish
  // round, then clamp on the guard-extended word
  function automatic logic [16:0] m_st(logic [39:0] a, logic r, logic c, logic e);
    logic [23:0] v;
    v = a[39:16] + (r & (c && a[15:0] == 16'h8000 ? a[16] : a[15]));
    if (e && !a[39] && v > 24'h007fff) return {1'b1, SAT_POS};
    if (e && a[39] && v < 24'hff8000) return {1'b1, SAT_NEG};
    return {1'b0, v[15:0]};
  endfunction : m_st
  // random traffic; guards of 00, ff, 01, 02 reach both clamps, and every
  // 13th load rounds up onto the negative limit, which must not clamp
  initial
  begin
    void'($urandom(70));
    repeat (16) @(posedge clk);
    @(negedge clk) reset_n <= 1;
    for (int i = 0; i < 400; i++)
    begin
      @(negedge clk);
      s = $urandom % 3;
      n = (i % 7 == 0) ? 0 : int'($urandom % 41) - 20;
      if (s == 2 && n == 0) n = 1;
      shift_req <= '{1'($urandom), dwss_src_t'(s), 1'($urandom), 6'(n)};
      store_req <= 4'($urandom);
      data_write_sat_enable <= 1'($urandom);
      a_in <= i % 13 == 6 ? {24'hff7fff, 16'hc000} :
        {8'($urandom % 4 - 1), 16'($urandom), i % 5 ? 16'($urandom) : 16'h8000};
      b_in <= i % 13 == 6 ? {24'hff7fff, 16'hc000} : {8'($urandom % 4 - 1), 32'($urandom)};
      x_bus <= 16'($urandom);
      #1;
      es = m_st(store_req.use_b ? pb : pa, store_req.round_en, store_req.convergent,
        data_write_sat_enable);
      if (store_req.valid)
      begin
        chk(store_data, es[15:0]);
        chk(store_clamped, es[16]);
      end
      op = s == 0 ? pa : s == 1 ? pb : n > 0 ?
        {{8{~shift_req.logical & x_bus[15]}}, x_bus, 16'h0} : {24'h0, x_bus};
      n = n > 16 ? 16 : n < -16 ? -16 : n;
      if (shift_req.valid)
      begin
        if (n < 0) m_acc = op << -n;
        else if (shift_req.logical) m_acc = op >> n;
        else m_acc = $signed(op) >>> n;
        m_wd = s == 2 && n > 0 ? m_acc[31:16] : m_acc[15:0];
      end
      @(posedge clk) #1;
      chk(shift_acc_result, m_acc);
      chk(shift_word_result, m_wd);
      chk(shift_done, shift_req.valid);
      pa = a_in;
      pb = b_in;
    end
    tally_and_finish;
  end
endmodule : dwss_core_bench

// ---- bench/dwss_core_sva.sv ----
`timescale 1ns/100ps
module dwss_core_sva
  import dwss_pkg::*;
#(parameter int ACC_WIDTH = ACC_W)
(
  // clock and reset
  input wire logic              clk,
  input wire logic              reset_n,
  // core state
  input wire logic [ACC_W-1:0]  accumulator_a,
  input wire logic [ACC_W-1:0]  accumulator_b,
  input wire logic              data_write_sat_enable,
  // store path
  input wire dwss_store_req_t   store_req,
  input wire logic [WORD_W-1:0] store_data,
  input wire logic              store_valid,
  input wire logic              store_clamped,
  // shift path
  input wire dwss_shift_req_t   shift_req,
  input wire logic [ACC_W-1:0]  shift_acc_result,
  input wire logic              shift_done
);
  // accumulator feeding the store
  wire [ACC_W-1:0] src = store_req.use_b ? accumulator_b : accumulator_a;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // shift request, and a zero-amount one on accumulator a
  sequence s_req; shift_req.valid; endsequence
  sequence s_pass;
    s_req ##0 (shift_req.amount == 0 && shift_req.src == DWSS_SRC_ACC_A);
  endsequence
  AST_VALID: assert property (store_valid == store_req.valid)
    else $error("store valid wrong");
  AST_NOSAT: assert property (!data_write_sat_enable |-> !store_clamped)
    else $error("clamped while disabled");
  AST_POS: assert property (store_clamped && !src[39] |-> store_data == 16'h7fff)
    else $error("positive clamp wrong");
  AST_NEG: assert property (store_clamped && src[39] |-> store_data == 16'h8000)
    else $error("negative clamp wrong");
  AST_TRUNC: assert property (store_req.valid && !store_req.round_en && !store_clamped
    |-> store_data == src[31:16]) else $error("truncated word wrong");
  AST_DONE: assert property (s_req |=> shift_done)
    else $error("shift not done in one cycle");
  AST_IDLE: assert property (!shift_req.valid |=> !shift_done
    && $stable(shift_acc_result)) else $error("shift output moved while idle");
  AST_ZERO: assert property (s_pass |=> shift_acc_result == $past(accumulator_a))
    else $error("zero shift changed operand");
endmodule : dwss_core_sva

bind dwss_core dwss_core_sva #(.ACC_WIDTH(ACC_WIDTH)) dwss_core_sva_inst (.*);

// ---- bench/dwss_partner.sv ----
`timescale 1ns/100ps
module dwss_partner
  import dwss_pkg::*;
(
  // clock and next state
  input wire logic             clk,
  input wire logic [ACC_W-1:0] a_in,
  input wire logic [ACC_W-1:0] b_in,
  // state seen by the core
  output logic [ACC_W-1:0]     accumulator_a = '0,
  output logic [ACC_W-1:0]     accumulator_b = '0
);
  // stores never write back, so accumulators move only here
  always @(negedge clk)
  begin
    accumulator_a <= a_in;
    accumulator_b <= b_in;
  end
endmodule : dwss_partner

// ---- hdl/dwss_core.sv ----
`timescale 1ns/100ps

// How it works
// - write saturation alters only the stored word, never the source accumulator.
// - the saturation stage takes the 24-bit rounded view of accumulator bits 39..16, with round carry, plus accumulator bit 39.
// - with saturation enabled a value above 0x007fff is stored as 0x7fff.
// - with saturation enabled a value below 0xff8000 is stored as 0x8000.
// - the sign used by the saturation test is accumulator bit 39.
// - with saturation disabled the rounded or truncated word is stored unchanged.
// - the shifter does up to 16-bit arithmetic or logical right, or left, shifts in one cycle.
// - the shift operand comes from accumulator a, accumulator b or the x bus.
// - a positive amount shifts right, negative shifts left, zero passes through.
// - the shifter is 40 bits wide with a 40-bit and a 16-bit result.
// - x bus data enters at bits 16..31 for right shifts and bits 0..15 for left shifts.
// - without rounding the store is truncated and the low word dropped.
module dwss_core
  import dwss_pkg::*;
#(
  parameter int ACC_WIDTH = ACC_W
)
(
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 reset_n,
  // core state
  input  wire logic [ACC_W-1:0]     accumulator_a,
  input  wire logic [ACC_W-1:0]     accumulator_b,
  input  wire logic [WORD_W-1:0]    x_bus,
  input  wire logic                 data_write_sat_enable,
  // store path
  input  wire dwss_store_req_t      store_req,
  output logic [WORD_W-1:0]         store_data,
  output logic                      store_valid,
  output logic                      store_clamped,
  // shift path
  input  wire dwss_shift_req_t      shift_req,
  output logic [ACC_W-1:0]          shift_acc_result,
  output logic [WORD_W-1:0]         shift_word_result,
  output logic                      shift_done
);

  // two independent paths share the accumulator inputs: a store path that
  // rounds and clamps a word for data memory with no clock in the way, and
  // a shift path whose results are registered one cycle after the request

  // widths of the fill and pad fields around an x bus word in the frame
  localparam int XFILL_W = ACC_W - HI_MSB - 1;
  localparam int XPAD_W  = ACC_W - WORD_W;

  // store path
  logic [ACC_W-1:0]   store_src;
  logic [WORD_W-1:0]  sat_word;
  logic               sat_hit;

  // shift path: decoded request, framed operand and the values that the
  // result registers load on the next edge
  logic [ACC_W-1:0]   operand;
  logic [ACC_W-1:0]   next_shift;
  logic [WORD_W-1:0]  next_word;
  logic [SHAMT_W-1:0] mag;
  logic               right;
  logic               xbus_src;

  // pick one of the two accumulators by a select bit; the store source
  // and the shift operand both go through here
  function automatic logic [ACC_W-1:0] pick_acc(
    input logic             sel_b,
    input logic [ACC_W-1:0] acc_a,
    input logic [ACC_W-1:0] acc_b
  );
    return sel_b ? acc_b : acc_a;
  endfunction : pick_acc

  // direction from the sign bit; zero counts as right, and a right shift
  // by zero moves nothing
  function automatic logic shift_is_right(input logic signed [SHAMT_W-1:0] a);
    return !a[SHAMT_W-1];
  endfunction : shift_is_right

  // magnitude of the signed amount, clipped at 16 rather than wrapped so a
  // stray amount never turns into a shift the other way
  function automatic logic [SHAMT_W-1:0] shift_mag(input logic signed [SHAMT_W-1:0] a);
    logic [SHAMT_W-1:0] m;
    // negating the most negative amount gives 32, which is then clipped
    m = a[SHAMT_W-1] ? SHAMT_W'(-a) : SHAMT_W'(a);
    if (m > SHAMT_W'(MAX_SHIFT))
      m = SHAMT_W'(MAX_SHIFT);
    return m;
  endfunction : shift_mag

  // x bus word framed in 40 bits: high word for right shifts so bits fall
  // into the low word, low word for left shifts so bits climb upward
  function automatic logic [ACC_W-1:0] place_xbus(
    input logic [WORD_W-1:0] x,
    input logic              to_right,
    input logic              logical
  );
    logic             fill;
    logic [ACC_W-1:0] framed;
    // sign fill of the guard bits only for an arithmetic right shift
    fill = x[WORD_W-1] & !logical;
    if (to_right)
      framed = {{XFILL_W{fill}}, x, {HI_LSB{1'b0}}};
    else
      framed = {{XPAD_W{1'b0}}, x};
    return framed;
  endfunction : place_xbus

  // one-pass barrel shift; a left shift ignores the logical bit
  function automatic logic [ACC_W-1:0] barrel(
    input logic [ACC_W-1:0]   op,
    input logic [SHAMT_W-1:0] amt,
    input logic               to_right,
    input logic               logical
  );
    logic [ACC_W-1:0] res;
    // an arithmetic right shift fills from bit 39 of the frame
    if (!to_right)
      res = op << amt;
    else if (logical)
      res = op >> amt;
    else
      res = ACC_W'($signed(op) >>> amt);
    return res;
  endfunction : barrel

  // 16-bit view of a shift result, from the high word or the low word
  function automatic logic [WORD_W-1:0] pick_word(
    input logic [ACC_W-1:0] res,
    input logic             from_high
  );
    return from_high ? res[HI_MSB:HI_LSB] : res[WORD_W-1:0];
  endfunction : pick_word

  // source accumulator is read only; nothing here writes back, so the
  // clamp never reaches the accumulator it was taken
  assign store_src = pick_acc(store_req.use_b, accumulator_a, accumulator_b);

  // round and saturate in one combinational pass; rounding mode and the
  // truncate choice come with each store, the clamp enable is a level
  // from the core control register
  dwss_round_sat u_round_sat (
    // accumulator, per-store controls and the clamp enable level
    .acc        (store_src),
    .round_en   (store_req.round_en),
    .convergent (store_req.convergent),
    .sat_enable (data_write_sat_enable),
    // stored word and clamp flag
    .wr_data    (sat_word),
    .clamped    (sat_hit)
  );

  // store word is combinational so the memory write sees it this cycle
  assign store_data    = sat_word;
  // valid passes straight through; there is nothing to wait for
  assign store_valid   = store_req.valid;
  // the clamp flag only counts alongside a store
  assign store_clamped = store_req.valid & sat_hit;

  // decode direction and magnitude; amounts past 16 either way are clipped
  always_comb
  begin
    right    = shift_is_right(shift_req.amount);
    mag      = shift_mag(shift_req.amount);
    xbus_src = (shift_req.src == DWSS_SRC_XBUS);
  end

  // operand select; the spare source code shifts zero, not stale data
  always_comb
  begin
    case (shift_req.src)
      DWSS_SRC_ACC_A,
      DWSS_SRC_ACC_B: operand = pick_acc(shift_req.src == DWSS_SRC_ACC_B, accumulator_a,
                                         accumulator_b);
      DWSS_SRC_XBUS:  operand = place_xbus(x_bus, right, shift_req.logical);
      default:        operand = '0;
    endcase
  end

  // barrel shift in one pass
  always_comb
  begin
    next_shift = barrel(operand, mag, right, shift_req.logical);
  end

  // 16-bit view: an x bus right shift reads the high word frame, every
  // other case the low word
  always_comb
  begin
    next_word = pick_word(next_shift, xbus_src && right);
  end

  // 40-bit result; held between requests so a late reader still sees it,
  // at the cost of a load enable on all forty bits
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      shift_acc_result <= '0;
    else if (shift_req.valid)
      shift_acc_result <= next_shift;
  end

  // 16-bit result, loaded on the same requests as the 40-bit one
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      shift_word_result <= '0;
    else if (shift_req.valid)
      shift_word_result <= next_word;
  end

  // completion strobe, one cycle after each accepted request; back to
  // back requests keep it high
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      shift_done <= 1'b0;
    else
      shift_done <= shift_req.valid;
  end

endmodule : dwss_core

// ---- hdl/dwss_pkg.sv ----
package dwss_pkg;

  // datapath widths
  localparam int ACC_W      = 40;
  localparam int WORD_W     = 16;
  localparam int SIGN_BIT   = 39;
  localparam int HI_LSB     = 16;
  localparam int HI_MSB     = 31;
  localparam int GUARD_LSB  = 32;
  localparam int MAX_SHIFT  = 16;
  localparam int SHAMT_W    = 6;

  // write saturation values, 1.15
  localparam logic [15:0] SAT_POS = 16'h7fff;
  localparam logic [15:0] SAT_NEG = 16'h8000;
  localparam logic [15:0] HALF_LSW = 16'h8000;

  // saturation test limits on the 24-bit rounded view
  localparam int          TEST_W        = 24;
  localparam logic [23:0] SAT_POS_LIMIT = 24'h007fff;
  localparam logic [23:0] SAT_NEG_LIMIT = 24'hff8000;

  // shifter operand source
  typedef enum logic [1:0] {
    DWSS_SRC_ACC_A,
    DWSS_SRC_ACC_B,
    DWSS_SRC_XBUS
  } dwss_src_t;

  // store request into data memory
  typedef struct packed {
    logic        valid;
    logic        use_b;
    logic        round_en;
    logic        convergent;
  } dwss_store_req_t;

  // shift request
  typedef struct packed {
    logic                valid;
    dwss_src_t           src;
    logic                logical;
    logic signed [5:0]   amount;
  } dwss_shift_req_t;

endpackage : dwss_pkg

// ---- hdl/dwss_round_sat.sv ----
`timescale 1ns/100ps

// combinational round and data-space write saturation
module dwss_round_sat
  import dwss_pkg::*;
(
  // source accumulator and control
  input  wire logic [ACC_W-1:0]  acc,
  input  wire logic              round_en,
  input  wire logic              convergent,
  input  wire logic              sat_enable,
  // result
  output logic [WORD_W-1:0]      wr_data,
  output logic                   clamped
);

  logic [WORD_W-1:0] lo_word;
  logic              inc;
  logic [TEST_W-1:0] tested;

  // round adder on the 24-bit view, or plain truncation dropping the
  // low word; the view keeps the adder's carry for the overflow test
  always_comb
  begin
    lo_word = acc[HI_LSB-1:0];
    inc     = 1'b0;
    if (round_en)
    begin
      if (convergent && lo_word == HALF_LSW)
        inc = acc[HI_LSB];
      else
        inc = lo_word[WORD_W-1];
    end
    tested = acc[SIGN_BIT:HI_LSB] + TEST_W'(inc);
  end

  // saturation test on the rounded view with the sign from bit 39, so a
  // value rounded up onto the negative limit is not clamped; the
  // accumulator is only read here, never written back
  always_comb
  begin
    wr_data = tested[WORD_W-1:0];
    clamped = 1'b0;
    if (sat_enable)
    begin
      if (!acc[SIGN_BIT] && tested > SAT_POS_LIMIT)
      begin
        wr_data = SAT_POS;
        clamped = 1'b1;
      end
      else if (acc[SIGN_BIT] && tested < SAT_NEG_LIMIT)
      begin
        wr_data = SAT_NEG;
        clamped = 1'b1;
      end
    end
  end

endmodule : dwss_round_sat
